// *** src/alarm_trim_pkg.sv ***
// Register indices, field positions and reset values for the alarm and offset trim registers
package alarm_trim_pkg;

  // Bus and field widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int TRIM_W = 12;
  localparam int TRIM_REG_W = 16;
  localparam int LANES = 8;
  localparam int TRIMS = 3;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_ALARM_SUMMARY = 10'h2c0;
  localparam logic [9:0] IDX_ALARM_STATUS = 10'h2c1;
  localparam logic [9:0] IDX_ALARM_MASK = 10'h2c2;
  localparam logic [9:0] IDX_LANE_FIFO = 10'h2c4;
  localparam logic [9:0] IDX_TRIM0 = 10'h330;
  localparam logic [9:0] IDX_TRIM1 = 10'h332;
  localparam logic [9:0] IDX_TRIM2A = 10'h334;
  localparam logic [1:0] WORD_ALIGNED = 2'h0;

  // Reset values
  localparam logic [7:0] MASK_RESET = 8'h3f;
  localparam logic [7:0] STATUS_RESET = 8'h3f;
  localparam logic [7:0] LANE_FIFO_RESET = 8'hff;
  localparam logic [15:0] TRIM_RESET = 16'h0000;

  // Alarm status and mask bit positions
  localparam logic [7:0] ALARM_SRC_BITS = 8'h3d;
  localparam int BIT_FIFO = 5;
  localparam int BIT_PLL = 4;
  localparam int BIT_LINK = 3;
  localparam int BIT_REALIGN = 2;
  localparam int BIT_CLOCK = 0;

endpackage

// *** src/offset_trim_cell.sv ***
// One offset trim register with fuse default load and byte-masked write
`timescale 1ns/1ns
module offset_trim_cell (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Fuse default
  input wire logic fuse_load,
  input wire logic [alarm_trim_pkg::TRIM_W-1:0] fuse_value,
  // Register write
  input wire logic wr_en,
  input wire logic [alarm_trim_pkg::TRIM_REG_W-1:0] wr_data,
  input wire logic [alarm_trim_pkg::TRIM_REG_W-1:0] wr_mask,
  // Stored value
  output logic [alarm_trim_pkg::TRIM_REG_W-1:0] trim_q
);

  logic [alarm_trim_pkg::TRIM_REG_W-1:0] trim_d;

  // Next value: fuse default, then software write
  always_comb
  begin
    trim_d = trim_q;
    if (fuse_load)
    begin
      trim_d = {trim_q[alarm_trim_pkg::TRIM_REG_W-1:alarm_trim_pkg::TRIM_W], fuse_value};
    end
    if (wr_en)
    begin
      trim_d = (trim_q & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  // Trim storage
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      trim_q <= alarm_trim_pkg::TRIM_RESET;
    else
      trim_q <= trim_d;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_fuse_load_value: assert property (fuse_load && !wr_en |=> trim_q[alarm_trim_pkg::TRIM_W-1:0] == $past(fuse_value))
    else $error("trim did not take fuse default");

  a_trim_write_merge: assert property (wr_en |=> ((trim_q ^ $past(wr_data)) & $past(wr_mask)) == '0)
    else $error("trim write lost enabled bits");

  a_trim_hold_idle: assert property (!wr_en && !fuse_load |=> $stable(trim_q))
    else $error("trim changed without write or fuse load");

endmodule

// *** src/alarm_mask_offset_trim_regs.sv ***
// Alarm mask, per-lane FIFO alarm and offset trim registers behind an APB slave
//
// Behaviour
// - Set mask bit blocks its flag from summary.
// - Alarm mask resets to 0x3f, all masked.
// - Lane FIFO error sets that lane's alarm bit.
// - Write one clears lane bit; persisting error resets.
// - Writing summary FIFO flag one clears lanes.
// - Lane FIFO alarm register resets to 0xff.
// - Core 0 trim, 12-bit unsigned, drives offset.
// - That setup calibrates spare cores in foreground.
// - Core 1 trim, 12 bits, drives offset.
// - Core 2 trim applies only sampling input A.
// - Trim defaults come from fuse memory.
// - Summary bit reads one on unmasked flag.
// - Lane error sets FIFO summary flag, W1C.
`timescale 1ns/1ns
module alarm_mask_offset_trim_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [alarm_trim_pkg::ADDR_W-1:0] paddr,
  input wire logic [alarm_trim_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [alarm_trim_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Alarm sources
  input wire logic [alarm_trim_pkg::LANES-1:0] lane_fifo_error,
  input wire logic serdes_pll_unlock_flag,
  input wire logic link_state_flag,
  input wire logic clock_realign_flag,
  input wire logic divider_mismatch_flag,
  // Calibration state
  input wire logic offset_cal_busy,
  input wire logic background_cal_enable,
  input wire logic background_offset_cal_enable,
  input wire logic foreground_offset_cal_enable,
  input wire logic foreground_cal_complete,
  input wire logic core2_input_a_select,
  // Fuse defaults
  input wire logic [alarm_trim_pkg::TRIM_W-1:0] fuse_core0_trim,
  input wire logic [alarm_trim_pkg::TRIM_W-1:0] fuse_core1_trim,
  input wire logic [alarm_trim_pkg::TRIM_W-1:0] fuse_core2_input_a_trim,
  // Alarm and trim outputs
  output logic alarm_summary,
  output logic [alarm_trim_pkg::TRIM_W-1:0] core0_offset,
  output logic [alarm_trim_pkg::TRIM_W-1:0] core1_offset,
  output logic [alarm_trim_pkg::TRIM_W-1:0] core2_input_a_offset,
  output logic spare_core_fg_offset_cal
);

  // Register state
  logic [7:0] mask_q, mask_d;
  logic [7:0] status_q, status_d;
  logic [7:0] lane_q, lane_d;
  logic summary_q, summary_d;
  logic [alarm_trim_pkg::DATA_W-1:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [alarm_trim_pkg::TRIM_W-1:0] core2a_q, core2a_d;
  logic spare_q, spare_d;
  logic fuse_done_q, fuse_done_d;

  // Decode and helper terms
  logic setup, commit, wr, aligned, mapped, refused, trim_locked, trim_any;
  logic hit_summary, hit_status, hit_mask, hit_lane;
  logic [alarm_trim_pkg::TRIMS-1:0] hit_trim;
  logic [7:0] wmask8, status_set, status_clr, lane_clr, rsv_bits;
  logic [alarm_trim_pkg::TRIM_REG_W-1:0] wmask16;
  logic unmasked_any;
  logic [alarm_trim_pkg::TRIM_W-1:0] fuse_value [alarm_trim_pkg::TRIMS];
  logic [alarm_trim_pkg::TRIM_REG_W-1:0] trim_q [alarm_trim_pkg::TRIMS];
  logic [alarm_trim_pkg::TRIMS-1:0] trim_wr;

  // Fuse defaults per trim entry
  assign fuse_value[0] = fuse_core0_trim;
  assign fuse_value[1] = fuse_core1_trim;
  assign fuse_value[2] = fuse_core2_input_a_trim;

  // Address decode
  always_comb
  begin
    aligned = paddr[1:0] == alarm_trim_pkg::WORD_ALIGNED;
    hit_summary = aligned && paddr[11:2] == alarm_trim_pkg::IDX_ALARM_SUMMARY;
    hit_status = aligned && paddr[11:2] == alarm_trim_pkg::IDX_ALARM_STATUS;
    hit_mask = aligned && paddr[11:2] == alarm_trim_pkg::IDX_ALARM_MASK;
    hit_lane = aligned && paddr[11:2] == alarm_trim_pkg::IDX_LANE_FIFO;
    hit_trim[0] = aligned && paddr[11:2] == alarm_trim_pkg::IDX_TRIM0;
    hit_trim[1] = aligned && paddr[11:2] == alarm_trim_pkg::IDX_TRIM1;
    hit_trim[2] = aligned && paddr[11:2] == alarm_trim_pkg::IDX_TRIM2A;
    trim_any = |hit_trim;
    mapped = hit_summary | hit_status | hit_mask | hit_lane | trim_any;
  end

  // Trim access guard while calibration owns the trims
  always_comb
  begin
    trim_locked = offset_cal_busy
      | (background_cal_enable & background_offset_cal_enable)
      | (foreground_offset_cal_enable & ~foreground_cal_complete)
      | ~fuse_done_q;
  end

  // APB handshake, read data and write strobes
  always_comb
  begin
    setup = psel & ~penable;
    commit = psel & penable & pready_q;
    refused = ~mapped | (trim_any & trim_locked);
    pready_d = setup;
    pslverr_d = setup & refused;
    prdata_d = '0;
    if (setup && !refused && !pwrite)
    begin
      if (hit_summary)
        prdata_d = 32'(summary_q);
      else if (hit_status)
        prdata_d = 32'(status_q);
      else if (hit_mask)
        prdata_d = 32'(mask_q);
      else if (hit_lane)
        prdata_d = 32'(lane_q);
      else if (hit_trim[0])
        prdata_d = 32'(trim_q[0]);
      else if (hit_trim[1])
        prdata_d = 32'(trim_q[1]);
      else
        prdata_d = 32'(trim_q[2]);
    end
    wr = commit & pwrite & ~pslverr_q;
    wmask8 = {8{pstrb[0]}};
    wmask16 = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    trim_wr = wr ? hit_trim : '0;
  end

  // Alarm status, mask and lane flags; a set in the clearing cycle wins
  always_comb
  begin
    rsv_bits = ~alarm_trim_pkg::ALARM_SRC_BITS;
    mask_d = mask_q;
    if (wr && hit_mask)
    begin
      mask_d = (mask_q & ~wmask8) | (pwdata[7:0] & wmask8);
    end
    status_set = '0;
    status_set[alarm_trim_pkg::BIT_FIFO] = |lane_fifo_error;
    status_set[alarm_trim_pkg::BIT_PLL] = serdes_pll_unlock_flag;
    status_set[alarm_trim_pkg::BIT_LINK] = link_state_flag;
    status_set[alarm_trim_pkg::BIT_REALIGN] = clock_realign_flag;
    status_set[alarm_trim_pkg::BIT_CLOCK] = divider_mismatch_flag;
    status_clr = (wr && hit_status) ? (pwdata[7:0] & wmask8 & alarm_trim_pkg::ALARM_SRC_BITS) : '0;
    status_d = ((status_q & ~status_clr) | status_set) & alarm_trim_pkg::ALARM_SRC_BITS;
    if (wr && hit_status)
      status_d = status_d | (((status_q & ~wmask8) | (pwdata[7:0] & wmask8)) & rsv_bits);
    else
      status_d = status_d | (status_q & rsv_bits);
    lane_clr = (wr && hit_lane) ? (pwdata[7:0] & wmask8) : '0;
    if (status_clr[alarm_trim_pkg::BIT_FIFO])
      lane_clr = '1;
    lane_d = (lane_q & ~lane_clr) | lane_fifo_error;
  end

  // Summary alarm, core 2 gating, spare core calibration and fuse sequencing
  always_comb
  begin
    unmasked_any = |(status_q & ~mask_q & alarm_trim_pkg::ALARM_SRC_BITS);
    summary_d = unmasked_any;
    core2a_d = core2_input_a_select ? trim_q[2][alarm_trim_pkg::TRIM_W-1:0] : '0;
    spare_d = foreground_offset_cal_enable & background_cal_enable & ~background_offset_cal_enable;
    fuse_done_d = 1'b1;
  end

  // Register all state except the trims, which sit in the offset_trim_cell instances
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      mask_q <= alarm_trim_pkg::MASK_RESET;
      status_q <= alarm_trim_pkg::STATUS_RESET;
      lane_q <= alarm_trim_pkg::LANE_FIFO_RESET;
      summary_q <= 1'b0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      core2a_q <= '0;
      spare_q <= 1'b0;
      fuse_done_q <= 1'b0;
    end
    else
    begin
      mask_q <= mask_d;
      status_q <= status_d;
      lane_q <= lane_d;
      summary_q <= summary_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      core2a_q <= core2a_d;
      spare_q <= spare_d;
      fuse_done_q <= fuse_done_d;
    end
  end

  // Trim registers, fuse loaded in the first cycle after reset
  for (genvar i = 0; i < alarm_trim_pkg::TRIMS; i++)
  begin : g_trim
    offset_trim_cell u_trim (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .fuse_load(~fuse_done_q),
      .fuse_value(fuse_value[i]),
      .wr_en(trim_wr[i]),
      .wr_data(pwdata[alarm_trim_pkg::TRIM_REG_W-1:0]),
      .wr_mask(wmask16),
      .trim_q(trim_q[i])
    );
  end

  // Outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign alarm_summary = summary_q;
  assign core0_offset = trim_q[0][alarm_trim_pkg::TRIM_W-1:0];
  assign core1_offset = trim_q[1][alarm_trim_pkg::TRIM_W-1:0];
  assign core2_input_a_offset = core2a_q;
  assign spare_core_fg_offset_cal = spare_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access_done;
    psel && penable && pready;
  endsequence

  a_apb_one_wait: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not a single pulse after setup");

  a_trim_refused: assert property (s_setup and trim_any && trim_locked |=> pslverr && pready)
    else $error("locked trim access not refused");

  a_mask_reset_value: assert property (disable iff (1'b0) !resetn |=> mask_q == alarm_trim_pkg::MASK_RESET)
    else $error("mask reset value wrong");

  a_lane_reset_ones: assert property (disable iff (1'b0) !resetn |=> lane_q == alarm_trim_pkg::LANE_FIFO_RESET)
    else $error("lane alarm reset value wrong");

  a_lane_error_sets: assert property (1'b1 |=> (lane_q & $past(lane_fifo_error)) == $past(lane_fifo_error))
    else $error("lane error did not set its bit");

  a_lane_w1c_clear: assert property (s_access_done and wr && hit_lane && pstrb[0] |=>
    (lane_q & $past(pwdata[7:0]) & ~$past(lane_fifo_error)) == '0)
    else $error("lane bit not cleared by write one");

  a_fifo_flag_clears_lanes: assert property (wr && hit_status && pstrb[0] && pwdata[alarm_trim_pkg::BIT_FIFO] |=>
    lane_q == $past(lane_fifo_error))
    else $error("summary fifo clear missed lane bits");

  a_fifo_flag_sets: assert property (|lane_fifo_error |=> status_q[alarm_trim_pkg::BIT_FIFO])
    else $error("fifo summary flag not set");

  a_summary_follows: assert property (1'b1 |=> alarm_summary == $past(unmasked_any))
    else $error("summary alarm disagrees with flags and mask");

  a_mask_blocks_all: assert property ((mask_q & alarm_trim_pkg::ALARM_SRC_BITS) == alarm_trim_pkg::ALARM_SRC_BITS
    |=> !alarm_summary)
    else $error("fully masked alarms raised summary");

  a_core2_gated: assert property (!core2_input_a_select |=> core2_input_a_offset == '0)
    else $error("core 2 offset applied off input A");

  a_spare_cal: assert property (foreground_offset_cal_enable && background_cal_enable && !background_offset_cal_enable
    |=> spare_core_fg_offset_cal)
    else $error("spare core offset cal not requested");

  // Unmapped addresses answer with an error and no data
  a_unmapped_refused: assert property (s_setup and !mapped |=> pslverr && pready && prdata == '0)
    else $error("unmapped access not refused");

  // Status flags clear on a written one unless the source fires again
  a_status_w1c: assert property (wr && hit_status && pstrb[0] |=>
    (status_q & $past(pwdata[7:0] & alarm_trim_pkg::ALARM_SRC_BITS) & ~$past(status_set)) == '0)
    else $error("status flag not cleared by write one");

  // Mask takes the written byte whole
  a_mask_write: assert property (wr && hit_mask && pstrb[0] |=> mask_q == $past(pwdata[7:0]))
    else $error("mask write not stored");

endmodule

// *** tb/alarm_mask_offset_trim_regs_tb_top.sv ***
// Self-checking bench for the alarm mask, lane FIFO alarm and offset trim registers
`timescale 1ns/1ns
module alarm_mask_offset_trim_regs_tb_top;
  // Design inputs and outputs
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h3;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] lane_fifo_error = 8'h00;
  logic [5:0] flags = 6'h00; // Indexed by status bit position
  logic [4:0] cal = 5'h00; // Busy, bg, bg offset, fg offset, foreground_cal_complete
  logic sel_a = 1'b1;
  logic [11:0] fuse0, fuse1, fuse2;
  logic alarm_summary;
  logic [11:0] core0_offset, core1_offset, core2_input_a_offset;
  logic spare_core_fg_offset_cal;
  // Bench state
  int err_count = 0;
  int tests_run = 0;
  logic [32:0] exp_q[$];
  logic [4:0] cfg[7] = '{5'h10, 5'h0c, 5'h02, 5'h03, 5'h0b, 5'h08, 5'h04};
  int srcs[5] = '{0, 2, 3, 4, 5};
  int i, b, r;
  logic [11:0] v, t1;
  logic [4:0] c;
  logic e;

  alarm_mask_offset_trim_regs u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lane_fifo_error(lane_fifo_error), .serdes_pll_unlock_flag(flags[4]), .link_state_flag(flags[3]),
    .clock_realign_flag(flags[2]), .divider_mismatch_flag(flags[0]), .offset_cal_busy(cal[4]),
    .background_cal_enable(cal[3]), .background_offset_cal_enable(cal[2]),
    .foreground_offset_cal_enable(cal[1]), .foreground_cal_complete(cal[0]), .core2_input_a_select(sel_a),
    .fuse_core0_trim(fuse0), .fuse_core1_trim(fuse1), .fuse_core2_input_a_trim(fuse2),
    .alarm_summary(alarm_summary), .core0_offset(core0_offset), .core1_offset(core1_offset),
    .core2_input_a_offset(core2_input_a_offset), .spare_core_fg_offset_cal(spare_core_fg_offset_cal)
  );

  // Clock
  always #5 sys_clk = ~sys_clk;

  task automatic close_out;
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; expected error flag and read data go to the queue
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
    exp_q.push_back(exp);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    // Hold the request until pready is seen high; the watchdog ends a hung wait
    while (pready !== 1'b1)
    begin
      @(posedge sys_clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One-cycle pulse on an alarm source
  task automatic pulse(input int s);
    @(posedge sys_clk);
    if (s == 5)
      lane_fifo_error <= 8'h01;
    else
      flags[s] <= 1'b1;
    @(posedge sys_clk);
    lane_fifo_error <= 8'h00;
    flags <= 6'h00;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Bus answer checker, taken at the edge where pready is sampled high
  always @(posedge sys_clk)
  begin
    if (pready === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        err_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, {pslverr, prdata}, 33'h0);
      end
      else
        cmp({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // Watchdog
  initial
  begin
    #200000;
    err_count++;
    close_out();
  end

  // Main sequence
  initial
  begin
    r = $urandom(32'h2907624b);
    fuse0 = 12'($urandom);
    fuse1 = 12'($urandom);
    fuse2 = 12'($urandom);
    t1 = fuse1;
    settle(2);
    resetn <= 1'b1;
    settle(3);
    apb(1'b0, 12'hb08, 32'h0, 33'h3f);
    apb(1'b0, 12'hb10, 32'h0, 33'hff);
    apb(1'b0, 12'hcc0, 32'h0, {21'h0, fuse0});
    apb(1'b0, 12'hcc8, 32'h0, {21'h0, fuse1});
    apb(1'b0, 12'hcd0, 32'h0, {21'h0, fuse2});
    apb(1'b0, 12'h004, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'hb09, 32'h0, {1'b1, 32'h0});
    v = 12'($urandom);
    apb(1'b1, 12'hcc0, {20'h0, v}, 33'h0);
    settle(1);
    cmp(33'(core0_offset), 33'(v));
    apb(1'b0, 12'hcc0, 32'h0, {21'h0, v});
    v = 12'($urandom);
    apb(1'b1, 12'hcd0, {20'h0, v}, 33'h0);
    settle(2);
    cmp(33'(core2_input_a_offset), 33'(v));
    sel_a <= 1'b0;
    settle(2);
    cmp(33'(core2_input_a_offset), 33'h0);
    // Calibration configurations against trim access
    for (i = 0; i < 7; i++)
    begin
      c = cfg[i];
      e = c[4] | (c[3] & c[2]) | (c[1] & ~c[0]);
      @(posedge sys_clk);
      cal <= c;
      settle(2);
      cmp(33'(spare_core_fg_offset_cal), 33'(c[1] & c[3] & ~c[2]));
      v = 12'($urandom);
      apb(1'b1, 12'hcc8, {20'h0, v}, {e, 32'h0});
      if (!e)
        t1 = v;
      cal <= 5'h00;
      apb(1'b0, 12'hcc8, 32'h0, {21'h0, t1});
      cmp(33'(core1_offset), 33'(t1));
    end
    // Lane FIFO alarm flags
    apb(1'b1, 12'hb04, 32'h3f, 33'h0);
    apb(1'b0, 12'hb10, 32'h0, 33'h00);
    r = $urandom % 8;
    @(posedge sys_clk);
    lane_fifo_error <= 8'h01 << r;
    @(posedge sys_clk);
    lane_fifo_error <= 8'h00;
    apb(1'b0, 12'hb10, 32'h0, 33'(8'h01 << r));
    apb(1'b0, 12'hb04, 32'h0, 33'h22);
    lane_fifo_error <= 8'h40;
    apb(1'b1, 12'hb10, 32'hff, 33'h0);
    apb(1'b0, 12'hb10, 32'h0, 33'h40);
    lane_fifo_error <= 8'h00;
    apb(1'b1, 12'hb10, 32'h40, 33'h0);
    apb(1'b0, 12'hb10, 32'h0, 33'h00);
    // Mask gating of each alarm source into the summary bit
    apb(1'b1, 12'hb04, 32'h3f, 33'h0);
    for (i = 0; i < 5; i++)
    begin
      b = srcs[i];
      pulse(b);
      settle(3);
      cmp(33'(alarm_summary), 33'h0);
      apb(1'b1, 12'hb08, 32'(8'h3f ^ (8'h01 << b)), 33'h0);
      settle(3);
      cmp(33'(alarm_summary), 33'h1);
      apb(1'b0, 12'hb00, 32'h0, 33'h1);
      apb(1'b1, 12'hb04, 32'(8'h02 | (8'h01 << b)), 33'h0);
      settle(3);
      cmp(33'(alarm_summary), 33'h0);
      apb(1'b1, 12'hb08, 32'h3f, 33'h0);
    end
    // Second reset in mid-run
    apb(1'b1, 12'hb08, 32'h17, 33'h0);
    resetn <= 1'b0;
    settle(2);
    resetn <= 1'b1;
    settle(3);
    apb(1'b0, 12'hb08, 32'h0, 33'h3f);
    apb(1'b0, 12'hb10, 32'h0, 33'hff);
    apb(1'b0, 12'hcc0, 32'h0, {21'h0, fuse0});
    settle(2);
    close_out();
  end
endmodule
